// [embd_pkg.sv]
// Purpose: Shared constants and types for the external memory bank decoder
// Assumes: Word addresses are normal-word (32-bit) addresses
// Notes: Window bounds, timing defaults and request carriers live here
package embd_pkg;

    // ----------------------------------------------------------------
    // Address windows
    // ----------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam logic [31:0] ASYNC_B0_LO = 32'h0020_0000;
    localparam logic [31:0] ASYNC_B0_HI = 32'h007f_ffff;
    localparam logic [31:0] ASYNC_B1_LO = 32'h0400_0000;
    localparam logic [31:0] ASYNC_B2_LO = 32'h0800_0000;
    localparam logic [31:0] ASYNC_B3_LO = 32'h0c00_0000;
    localparam logic [31:0] ASYNC_BN_SPAN = 32'h007f_ffff;
    localparam logic [31:0] SYNC_B0_LO = 32'h0020_0000;
    localparam logic [31:0] SYNC_B0_HI = 32'h03ff_ffff;
    localparam logic [31:0] SYNC_BN_SPAN = 32'h03ff_ffff;
    localparam logic [31:0] FETCH_NW_LO = 32'h0020_0000;
    localparam logic [31:0] FETCH_NW_HI = 32'h005f_ffff;
    localparam logic [31:0] FETCH_SW_LO = 32'h0060_0000;
    localparam logic [31:0] FETCH_SW_HI = 32'h00ff_ffff;

    // ----------------------------------------------------------------
    // Capacity and timing fields
    // ----------------------------------------------------------------
    localparam int CAP_W = 3;
    localparam logic [2:0] CAP_MIN_4MB = 3'h0;
    localparam logic [2:0] CAP_MAX_256MB = 3'h6;
    localparam int TIM_W = 4;
    localparam logic [3:0] TIM_RESET = 4'h1;
    localparam int NBANK = 4;
    localparam int DATA_W = 64;

    // Request carried from each initiator
    typedef struct packed {
        logic valid;
        logic write;
        logic fetch;
        logic short_word;
        logic [31:0] addr;
        logic [63:0] wdata;
    } embd_req_t;

    // Per-bank configuration from the surrounding control logic
    typedef struct packed {
        logic is_sync;
        logic [2:0] capacity;
        logic [3:0] timing;
    } embd_bank_cfg_t;

    typedef enum logic [1:0] {
        EMBD_SRC_NONE,
        EMBD_SRC_CORE,
        EMBD_SRC_DMA
    } embd_src_t;

endpackage

// [embd_decoder.sv]
// Purpose: Maps core and DMA requests onto four external memory banks
// Assumes: Single clock, synchronous reset, inputs synchronous to i_clk
// Notes: One access at a time; a started access runs for its bank timing
`timescale 1ns/100ps
module embd_decoder
    import embd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire embd_req_t i_core_req,
    input wire embd_req_t i_dma_req,
    input wire embd_bank_cfg_t [NBANK-1:0] i_bank_cfg,
    input wire logic i_paired_mode,
    output logic o_core_ack,
    output logic o_dma_ack,
    output logic o_core_err,
    output logic o_dma_err,
    output logic [NBANK-1:0] o_bank_sel_n,
    output logic o_sync_cycle,
    output logic o_async_cycle,
    output logic o_write,
    output logic [ADDR_W-1:0] o_addr,
    output logic [DATA_W-1:0] o_data,
    output logic [7:0] o_byte_en,
    output logic o_busy
);

    // ----------------------------------------------------------------
    // Arbitration
    // ----------------------------------------------------------------
    logic busy_r;
    logic last_dma_r;
    logic [3:0] wait_r;
    embd_src_t owner_r;
    embd_src_t grant;
    embd_req_t sel_req;

    // Round robin so neither initiator can starve the other
    always_comb begin
        grant = EMBD_SRC_NONE;
        if (i_core_req.valid && i_dma_req.valid) begin
            grant = last_dma_r ? EMBD_SRC_CORE : EMBD_SRC_DMA;
        end else if (i_core_req.valid) begin
            grant = EMBD_SRC_CORE;
        end else if (i_dma_req.valid) begin
            grant = EMBD_SRC_DMA;
        end
        sel_req = (grant == EMBD_SRC_DMA) ? i_dma_req : i_core_req;
    end

    // ----------------------------------------------------------------
    // Window decode
    // ----------------------------------------------------------------
    logic [NBANK-1:0] hit;
    logic [31:0] a;
    logic fetch_ok;
    logic any_hit;
    logic [2:0] cap_limit;

    assign a = sel_req.addr;

    // Per-bank window, choosing sync or async bounds by bank type
    genvar g;
    generate
        for (g = 0; g < NBANK; g++) begin : g_bank
            logic [31:0] lo;
            logic [31:0] hi;
            logic [31:0] cap_hi;
            always_comb begin
                cap_hi = 32'h0;
                if (g == 0) begin
                    lo = i_bank_cfg[g].is_sync ? SYNC_B0_LO
                        : ASYNC_B0_LO;
                    hi = i_bank_cfg[g].is_sync ? SYNC_B0_HI
                        : ASYNC_B0_HI;
                end else begin
                    lo = (g == 1) ? ASYNC_B1_LO
                        : (g == 2) ? ASYNC_B2_LO : ASYNC_B3_LO;
                    hi = lo + (i_bank_cfg[g].is_sync ? SYNC_BN_SPAN
                        : ASYNC_BN_SPAN);
                end
                // Sync banks 1 to 3 also bounded by fitted capacity in words
                cap_hi = lo + ((32'h0010_0000 << cap_limit) - 32'h1);
                if (i_bank_cfg[g].is_sync && g != 0 && cap_hi < hi) begin
                    hi = cap_hi;
                end
            end
            assign hit[g] = (a >= lo) && (a <= hi);
        end
    endgenerate

    // Capacity field clamped to the legal 4 to 256 Mbyte span
    always_comb begin
        cap_limit = 3'h0;
        if (grant != EMBD_SRC_NONE) begin
            cap_limit = i_bank_cfg[0].capacity;
        end
        for (int i = 0; i < NBANK; i++) begin
            if (hit_raw_bank(i)) begin
                cap_limit = i_bank_cfg[i].capacity;
            end
        end
        if (cap_limit > CAP_MAX_256MB) begin
            cap_limit = CAP_MAX_256MB;
        end
        if (cap_limit < CAP_MIN_4MB) begin
            cap_limit = CAP_MIN_4MB;
        end
    end

    // Coarse bank index from the top address bits, no window check
    function automatic logic hit_raw_bank(input int idx);
        hit_raw_bank = (a[27:26] == idx[1:0]) && (a[31:28] == 4'h0);
    endfunction

    // Code only from bank 0, inside its fetch range for the format
    always_comb begin
        fetch_ok = 1'b1;
        if (sel_req.fetch) begin
            if (sel_req.short_word) begin
                fetch_ok = hit[0] && (a >= FETCH_SW_LO)
                    && (a <= FETCH_SW_HI);
            end else begin
                fetch_ok = hit[0] && (a >= FETCH_NW_LO)
                    && (a <= FETCH_NW_HI);
            end
        end
    end

    assign any_hit = (|hit) && fetch_ok;

    // ----------------------------------------------------------------
    // Access sequencing
    // ----------------------------------------------------------------
    logic [1:0] bank_idx;
    logic start;

    always_comb begin
        bank_idx = 2'h0;
        for (int i = 0; i < NBANK; i++) begin
            if (hit[i]) begin
                bank_idx = i[1:0];
            end
        end
    end

    // No take while an error pulse stands: the refused initiator has not
    // yet seen it, so its request is still up and would be taken twice
    assign start = !busy_r && (grant != EMBD_SRC_NONE)
        && !o_core_err && !o_dma_err;

    // Busy and wait count; each bank keeps its own timing value
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            busy_r <= 1'b0;
            wait_r <= 4'h0;
            owner_r <= EMBD_SRC_NONE;
        end else if (start && any_hit) begin
            busy_r <= 1'b1;
            wait_r <= i_bank_cfg[bank_idx].timing;
            owner_r <= grant;
        end else if (busy_r) begin
            if (wait_r == 4'h0) begin
                busy_r <= 1'b0;
                owner_r <= EMBD_SRC_NONE;
            end else begin
                wait_r <= wait_r - 4'h1;
            end
        end
    end

    // Fairness memory for the round robin
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            last_dma_r <= 1'b0;
        end else if (start) begin
            last_dma_r <= (grant == EMBD_SRC_DMA);
        end
    end

    // ----------------------------------------------------------------
    // Pin side outputs
    // ----------------------------------------------------------------
    // Select lines are active low, one per bank
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_bank_sel_n <= 4'hf;
            o_sync_cycle <= 1'b0;
            o_async_cycle <= 1'b0;
            o_write <= 1'b0;
            o_addr <= 32'h0;
            o_data <= 64'h0;
            o_byte_en <= 8'h0;
        end else if (start && any_hit) begin
            o_bank_sel_n <= ~(4'h1 << bank_idx);
            o_sync_cycle <= i_bank_cfg[bank_idx].is_sync;
            o_async_cycle <= !i_bank_cfg[bank_idx].is_sync;
            o_write <= sel_req.write;
            o_addr <= a;
            o_data <= sel_req.wdata;
            // Paired mode only widens sync transfers to 64 bits
            o_byte_en <= (i_paired_mode && i_bank_cfg[bank_idx].is_sync)
                ? 8'hff : 8'h0f;
        end else if (busy_r && wait_r == 4'h0) begin
            o_bank_sel_n <= 4'hf;
            o_sync_cycle <= 1'b0;
            o_async_cycle <= 1'b0;
            o_write <= 1'b0;
            o_byte_en <= 8'h0;
        end
    end

    // Acks pulse when the access ends; unmapped requests error at once
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_core_ack <= 1'b0;
            o_dma_ack <= 1'b0;
            o_core_err <= 1'b0;
            o_dma_err <= 1'b0;
        end else begin
            o_core_ack <= busy_r && wait_r == 4'h0
                && owner_r == EMBD_SRC_CORE;
            o_dma_ack <= busy_r && wait_r == 4'h0
                && owner_r == EMBD_SRC_DMA;
            o_core_err <= start && !any_hit
                && grant == EMBD_SRC_CORE;
            o_dma_err <= start && !any_hit
                && grant == EMBD_SRC_DMA;
        end
    end

    // Mirror of the busy state for the initiators
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (start && any_hit) || (busy_r && wait_r != 4'h0);
        end
    end

endmodule

// [embd_asserts.sv]
// Purpose: Port checks for the bank decoder
// Assumes: Bound to every embd_decoder
// Notes: Select lines are active low
`timescale 1ns/100ps
module embd_asserts
    import embd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire embd_bank_cfg_t [NBANK-1:0] i_bank_cfg,
    input wire logic i_paired_mode,
    input wire logic o_core_ack,
    input wire logic o_dma_ack,
    input wire logic o_core_err,
    input wire logic o_dma_err,
    input wire logic [NBANK-1:0] o_bank_sel_n,
    input wire logic o_sync_cycle,
    input wire logic o_async_cycle,
    input wire logic [ADDR_W-1:0] o_addr,
    input wire logic [7:0] o_byte_en,
    input wire logic o_busy
);
    logic [3:0] sel;
    logic [3:0] syn;
    logic [4:0] cnt_r;
    logic [3:0] tim_r;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // Active-high view of selects and bank types
    assign sel = ~o_bank_sel_n;
    assign syn = {i_bank_cfg[3].is_sync, i_bank_cfg[2].is_sync,
                  i_bank_cfg[1].is_sync, i_bank_cfg[0].is_sync};
    // Select length, compared with the bank timing at the end
    always_ff @(posedge i_clk) begin
        if (i_srst || sel == 4'h0) begin
            cnt_r <= 5'h0;
        end else begin
            cnt_r <= cnt_r + 5'h1;
        end
    end
    // Timing of the bank in use; no reset, read only after a select
    always_ff @(posedge i_clk) begin
        for (int b = 0; b < NBANK; b++) begin
            if (sel[b]) begin
                tim_r <= i_bank_cfg[b].timing;
            end
        end
    end
    sequence acc_end;
        $fell(|sel);
    endsequence
    sequence any_done;
        o_core_ack || o_dma_ack;
    endsequence
    sel_onehot_a: assert property ($onehot0(sel))
        else $error("more than one bank selected");
    sel_busy_a: assert property (|sel |-> o_busy)
        else $error("select without busy");
    err_nosel_a: assert property ((o_core_err || o_dma_err) |->
        sel == 4'h0 && !o_sync_cycle && !o_async_cycle)
        else $error("refused access started a cycle");
    type_pick_a: assert property (|sel |->
        o_sync_cycle == |(sel & syn) && o_async_cycle == !o_sync_cycle)
        else $error("cycle type differs from bank type");
    end_ack_a: assert property (acc_end |-> o_core_ack ^ o_dma_ack)
        else $error("access end without a single ack");
    acc_len_a: assert property (acc_end |->
        cnt_r == {1'b0, tim_r} + 5'h1)
        else $error("access length differs from bank timing");
    ack_pulse_a: assert property (any_done |=>
        !o_core_ack && !o_dma_ack)
        else $error("ack longer than one cycle");
    attr_hold_a: assert property ((|sel && $past(|sel)) |->
        $stable(o_addr) && $stable(o_bank_sel_n))
        else $error("attributes moved during access");
    byte_lane_a: assert property (|sel |-> o_byte_en ==
        ((i_paired_mode && o_sync_cycle) ? 8'hff : 8'h0f))
        else $error("wrong byte lanes");
endmodule
bind embd_decoder embd_asserts u_chk (.i_clk(i_clk), .i_srst(i_srst),
    .i_bank_cfg(i_bank_cfg), .i_paired_mode(i_paired_mode),
    .o_core_ack(o_core_ack), .o_dma_ack(o_dma_ack),
    .o_core_err(o_core_err), .o_dma_err(o_dma_err),
    .o_bank_sel_n(o_bank_sel_n), .o_sync_cycle(o_sync_cycle),
    .o_async_cycle(o_async_cycle), .o_addr(o_addr),
    .o_byte_en(o_byte_en), .o_busy(o_busy));

// [embd_mem_model.sv]
// Purpose: Behavioural memories on the four bank selects
// Assumes: 16-bit parts, one per bank
// Notes: Keeps the last halfword written to each bank
`timescale 1ns/100ps
module embd_mem_model (
    input wire logic i_clk,
    input wire logic [3:0] i_sel_n,
    input wire logic i_write,
    input wire logic [63:0] i_data
);
    // Narrow parts only, never 32 bits wide
    logic [15:0] mem_r [4];
    // Each part answers to its own select only
    always_ff @(posedge i_clk) begin
        for (int b = 0; b < 4; b++) begin
            if (!i_sel_n[b] && i_write) begin
                mem_r[b] <= i_data[15:0];
            end
        end
    end
endmodule

// [external_memory_bank_decoder_test.sv]
// Purpose: Self-checking bench for the bank decoder
// Assumes: Inputs move 2 ns after the rising edge
// Notes: Note is {expected selects, expected error}
`timescale 1ns/100ps
module external_memory_bank_decoder_test;
    import embd_pkg::*;
    localparam logic [4:0] S0 = 5'b11100, S1 = 5'b11010;
    localparam logic [4:0] S2 = 5'b10110, S3 = 5'b01110, ER = 5'b11111;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic paired = 1'b0;
    embd_req_t core_req = '0;
    embd_req_t dma_req = '0;
    embd_bank_cfg_t [NBANK-1:0] cfg = '0;
    logic core_ack, dma_ack, core_err, dma_err, busy, wr;
    logic [3:0] sel_n;
    logic [63:0] data;
    logic [4:0] notes [$];
    logic [3:0] seen = 4'hf;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 32'hb3d8;
    embd_decoder uut (.i_clk(i_clk), .i_srst(i_srst),
        .i_core_req(core_req), .i_dma_req(dma_req), .i_bank_cfg(cfg),
        .i_paired_mode(paired), .o_core_ack(core_ack),
        .o_dma_ack(dma_ack), .o_core_err(core_err), .o_dma_err(dma_err),
        .o_bank_sel_n(sel_n), .o_sync_cycle(), .o_async_cycle(),
        .o_write(wr), .o_addr(), .o_data(data), .o_byte_en(),
        .o_busy(busy));
    embd_mem_model mem (.i_clk(i_clk), .i_sel_n(sel_n), .i_write(wr),
        .i_data(data));
    always #10 i_clk = ~i_clk;
    task automatic check(input logic [4:0] got, input logic [4:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One request held until its ack or error is seen
    task automatic go(input bit dma, input logic [2:0] k,
                      input logic [31:0] a, input logic [4:0] ex);
        embd_req_t r;
        r = {1'b1, k, a, $random(seed), $random(seed)};
        if (!k[1]) r.write = 1'($random(seed));
        @(posedge i_clk);
        #2;
        if (ex !== 5'h0) notes.push_back(ex);
        if (dma) dma_req = r; else core_req = r;
        for (int n = 0; n < 40; n++) begin
            @(posedge i_clk);
            #1;
            if (dma ? dma_ack | dma_err : core_ack | core_err) break;
        end
        #1;
        if (dma) dma_req.valid = 1'b0; else core_req.valid = 1'b0;
    endtask
    task automatic setc(input logic [3:0] sy);
        for (int b = 0; b < NBANK; b++) begin
            cfg[b] = {sy[b], 3'h6, 4'(1 + ($random(seed) & 3))};
        end
    endtask
    // Watcher: pops the oldest note on every ack or error
    always @(posedge i_clk) begin
        #1;
        if (sel_n != 4'hf) seen = sel_n;
        if (core_ack | dma_ack | core_err | dma_err) begin
            check({seen, core_err | dma_err},
                  notes.size() > 0 ? notes.pop_front() : 5'bx);
            seen = 4'hf;
        end
    end
    // Hang guard, far above the under two hundred cycles needed
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (6) @(posedge i_clk);
        #2;
        i_srst = 1'b0;
        paired = 1'b1;
        setc(4'h0);
        go(0, 3'b000, 32'h0020_0000, S0);
        go(0, 3'b000, 32'h007f_ffff, S0);
        go(0, 3'b000, 32'h0080_0000, ER);
        go(0, 3'b000, 32'h001f_ffff, ER);
        go(0, 3'b000, 32'h0400_0000 | 32'($random(seed)) & 32'h007f_ffff,
           S1);
        go(0, 3'b000, 32'h0480_0000, ER);
        go(0, 3'b000, 32'h087f_ffff, S2);
        go(0, 3'b000, 32'h0c7f_ffff, S3);
        go(0, 3'b000, 32'h0c80_0000, ER);
        $display("test async windows done");
        setc(4'hf);
        go(0, 3'b000, 32'h03ff_ffff, S0);
        go(0, 3'b000, 32'h0400_0000, S1);
        go(0, 3'b000, 32'h0bff_ffff, S2);
        go(0, 3'b000, 32'h0fff_ffff, S3);
        go(0, 3'b000, 32'h1000_0000, ER);
        $display("test sync windows done");
        paired = 1'b0;
        setc(4'h5);
        go(0, 3'b000, 32'h0300_0000, S0);
        go(0, 3'b000, 32'h0480_0000, ER);
        go(0, 3'b000, 32'h0bff_ffff, S2);
        go(0, 3'b000, 32'h0c80_0000, ER);
        $display("test mixed banks done");
        setc(4'h0);
        go(0, 3'b010, 32'h005f_ffff, S0);
        go(0, 3'b010, 32'h0060_0000, ER);
        go(0, 3'b011, 32'h0060_0000, S0);
        go(0, 3'b011, 32'h0080_0000, ER);
        go(0, 3'b010, 32'h0400_0000, ER);
        setc(4'h1);
        go(0, 3'b011, 32'h00ff_ffff, S0);
        go(0, 3'b011, 32'h0c00_0000, ER);
        $display("test fetch done");
        i_srst = 1'b1;
        repeat (2) @(posedge i_clk);
        #2;
        i_srst = 1'b0;
        notes.push_back(S1);
        notes.push_back(S2);
        // Tie right after reset: DMA is served first
        fork
            go(1, 3'b000, 32'h0400_0010, 5'h0);
            go(0, 3'b000, 32'h0800_0020, 5'h0);
        join
        $display("test arbitration done");
        repeat (2) @(posedge i_clk);
        check(5'(notes.size()), 5'h0);
        report_and_stop();
    end
endmodule
